// >>> hdl/ctn_defines.svh
`ifndef CTN_DEFINES_SVH
`define CTN_DEFINES_SVH

// Register offsets on the host serial port.
`define CTN_ADDR_RATIO_SEL    6'h29
`define CTN_ADDR_ALARM_FILT   6'h2A
`define CTN_ADDR_RUN_SWITCH   6'h2F
`define CTN_ADDR_REGION_GUARD 6'h30
`define CTN_ADDR_CUST_ID_LOW  6'h31
`define CTN_ADDR_CUST_ID_HIGH 6'h32
`define CTN_ADDR_NVRAM_CMD    6'h36
`define CTN_ADDR_TRIM_LOW     6'h3E
`define CTN_ADDR_TRIM_HIGH    6'h3F

// Field positions in the alarm and filter register.
`define CTN_BIT_C_MEDIAN      0
`define CTN_BIT_R_MEDIAN      1
`define CTN_BIT_SPEED_SEL     2
`define CTN_BIT_GATED_UPDATE  3
`define CTN_BIT_ALARM_LOW     4
`define CTN_BIT_ALARM_HIGH    6

// Writable bit masks; all other bits read as zero.
`define CTN_MASK_ALARM_FILT   8'h5F
`define CTN_MASK_RUN_SWITCH   8'h01
`define CTN_MASK_REGION_GUARD 8'h0F

// Memory control command codes.
`define CTN_CODE_STORE        8'h2D
`define CTN_CODE_RECALL       8'h59
`define CTN_CODE_ERASE        8'hB8

// NVRAM region boundaries guarded by the four lock bits.
`define CTN_REGION0_LAST      10'd703
`define CTN_REGION1_LAST      10'd831
`define CTN_REGION2_LAST      10'd959
`define CTN_REGION3_LAST      10'd1007
`define CTN_REGION3_TAIL      10'd1022

// Reset values.
`define CTN_RST_BYTE          8'h00
`define CTN_RST_TRIM_LOW      8'h00
`define CTN_RST_TRIM_HIGH     8'h00

`endif

// >>> hdl/ctn_pkg.sv
package ctn_pkg;

    // Memory control state, one-hot.
    typedef enum logic [1:0] {
        CTN_CMD_IDLE    = 2'b01,
        CTN_CMD_PENDING = 2'b10
    } ctn_cmd_state_e;

    // Register address on the host serial port.
    typedef logic [5:0] ctn_addr_t;

    // Register data byte.
    typedef logic [7:0] ctn_byte_t;

    // NVRAM word address.
    typedef logic [9:0] ctn_nv_addr_t;

endpackage

// >>> hdl/ctn_config_tail.sv
`timescale 1ns/1ns
`include "ctn_defines.svh"

module ctn_config_tail #(
    parameter int NUM_RESULTS = 8
) (
    // Clock, reset and clock enable.
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    // Register access from the host serial port decoder.
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire ctn_pkg::ctn_addr_t    reg_addr,
    input  wire ctn_pkg::ctn_byte_t    reg_wdata,
    output ctn_pkg::ctn_byte_t         reg_rdata,
    input  wire logic                  serial_activity,
    // NVRAM access check for the host serial port.
    input  wire logic                  nv_access_req,
    input  wire ctn_pkg::ctn_nv_addr_t nv_access_addr,
    output logic                       nv_access_allow,
    // NVRAM command starts and erase completion.
    output logic                       nv_store_start,
    output logic                       nv_recall_start,
    output logic                       nv_erase_start,
    input  wire logic                  nv_erase_done,
    // Result register update gating.
    input  wire logic [NUM_RESULTS-1:0] result_update,
    input  wire logic [NUM_RESULTS-1:0] result_read,
    output logic [NUM_RESULTS-1:0]     result_update_allow,
    // Front end and signal processor control.
    output logic                       frontend_run,
    output logic                       frontend_protect,
    // Firmware-facing configuration.
    output logic                       c_median_enable,
    output logic                       r_median_enable,
    output ctn_pkg::ctn_byte_t         resistance_ratio_sel,
    output logic [15:0]                pump_trim,
    // Alarm sources and general-purpose port outputs.
    input  wire logic [1:0]            alarm_z,
    input  wire logic [1:0]            alarm_theta,
    output logic                       general_port_zero,
    output logic                       general_port_one
);
    import ctn_pkg::*;

    // Elaboration check of the result count.
    if (NUM_RESULTS != 8) begin : g_num_results
        $error("NUM_RESULTS must be 8.");
    end

    // Register storage.
    ctn_byte_t      resistance_ratio_select;  // Ratio select byte.
    ctn_byte_t      alarm_and_filter_control; // Alarm and filter bits.
    ctn_byte_t      run_switch;               // Run switch, bit 0 only.
    ctn_byte_t      nvram_region_guard;       // Region locks, bits 3:0.
    ctn_byte_t      customer_id_low;          // Write-once serial low.
    ctn_byte_t      customer_id_high;         // Write-once serial high.
    ctn_byte_t      nvram_command;            // Memory control byte.
    ctn_byte_t      nvram_pump_trim_low;      // Trim low byte.
    ctn_byte_t      nvram_pump_trim_high;     // Trim high byte.
    ctn_cmd_state_e cmd_state;                // Command clear tracker.
    logic [NUM_RESULTS-1:0] result_unread;    // Result not yet read.

    // Qualified strobes; a frozen clock enable blocks all register reads and writes.
    // A strobe lost while frozen is gone.
    logic wr_q;
    logic rd_q;
    assign wr_q = reg_wr & clk_en;
    assign rd_q = reg_rd & clk_en;

    // Returns one when the address falls in a region whose lock is set.
    function automatic logic region_locked(input ctn_nv_addr_t a,
                                           input logic [3:0] lk);
        logic hit;
        hit = 1'b0;
        if (a <= `CTN_REGION0_LAST) begin
            hit = lk[0];
        end else if (a <= `CTN_REGION1_LAST) begin
            hit = lk[1];
        end else if (a <= `CTN_REGION2_LAST) begin
            hit = lk[2];
        end else if (a <= `CTN_REGION3_LAST) begin
            hit = lk[3];
        end else if (a >= `CTN_REGION3_TAIL) begin
            hit = lk[3];
        end
        // Words 1008 to 1021 never lock.
        return hit;
    endfunction

    // Returns one for a write strobe to the given register.
    function automatic logic wr_hit(input logic wr, input ctn_addr_t a,
                                    input ctn_addr_t target);
        return wr && (a == target);
    endfunction

    // Ratio select byte: stored as is for the linearizing firmware.
    // The firmware owns its meaning.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            resistance_ratio_select <= `CTN_RST_BYTE;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_RATIO_SEL)) begin
            resistance_ratio_select <= reg_wdata;
        end
    end

    // Alarm and filter bits; bits 7 and 5 are unused and stay zero.
    // Bit 2 is stored but drives nothing.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_and_filter_control <= `CTN_RST_BYTE;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_ALARM_FILT)) begin
            alarm_and_filter_control <= reg_wdata & `CTN_MASK_ALARM_FILT;
        end
    end

    // Run switch.  The host is expected to clear it before changing the
    // configuration; writes are not blocked while it is set, since the
    // host must be able to change it at all.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_switch <= `CTN_RST_BYTE;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_RUN_SWITCH)) begin
            run_switch <= reg_wdata & `CTN_MASK_RUN_SWITCH;
        end
    end

    // Region lock bits; upper nibble unused.
    // New locks apply to the next check.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nvram_region_guard <= `CTN_RST_BYTE;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_REGION_GUARD)) begin
            nvram_region_guard <= reg_wdata & `CTN_MASK_REGION_GUARD;
        end
    end

    // Serial number low byte: write once while zero, cleared by erase.
    // The erase wins over a same-cycle write so a full erase always
    // leaves the byte blank.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            customer_id_low <= `CTN_RST_BYTE;
        end else if (clk_en && nv_erase_done) begin
            customer_id_low <= `CTN_RST_BYTE;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_CUST_ID_LOW)
                     && (customer_id_low == `CTN_RST_BYTE)) begin
            customer_id_low <= reg_wdata;
        end
    end

    // Serial number high byte, same behaviour as the low byte.
    // Erase done is ignored while frozen.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            customer_id_high <= `CTN_RST_BYTE;
        end else if (clk_en && nv_erase_done) begin
            customer_id_high <= `CTN_RST_BYTE;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_CUST_ID_HIGH)
                     && (customer_id_high == `CTN_RST_BYTE)) begin
            customer_id_high <= reg_wdata;
        end
    end

    // Pump trim bytes are plain storage; the host must leave them alone.
    // Nothing here loads them from NVRAM.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nvram_pump_trim_low  <= `CTN_RST_TRIM_LOW;
            nvram_pump_trim_high <= `CTN_RST_TRIM_HIGH;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_TRIM_LOW)) begin
            nvram_pump_trim_low <= reg_wdata;
        end else if (wr_hit(wr_q, reg_addr, `CTN_ADDR_TRIM_HIGH)) begin
            nvram_pump_trim_high <= reg_wdata;
        end
    end

    // Memory control byte.  A write holds the code until the next serial
    // activity, which clears it.  The write cycle itself is not counted as
    // that activity; a new write in the pending state replaces the code.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nvram_command <= `CTN_RST_BYTE;
            cmd_state     <= CTN_CMD_IDLE;
        end else if (clk_en) begin
            case (cmd_state)
                CTN_CMD_IDLE: begin
                    // Waiting for a command write.
                    if (wr_hit(wr_q, reg_addr, `CTN_ADDR_NVRAM_CMD)) begin
                        nvram_command <= reg_wdata;
                        cmd_state     <= CTN_CMD_PENDING;
                    end
                end
                CTN_CMD_PENDING: begin
                    // Code held until the host talks again.
                    if (wr_hit(wr_q, reg_addr, `CTN_ADDR_NVRAM_CMD)) begin
                        nvram_command <= reg_wdata;
                    end else if (serial_activity) begin
                        nvram_command <= `CTN_RST_BYTE;
                        cmd_state     <= CTN_CMD_IDLE;
                    end
                end
                default: begin
                    // Drop any pending code.
                    nvram_command <= `CTN_RST_BYTE;
                    cmd_state     <= CTN_CMD_IDLE;
                end
            endcase
        end
    end

    // One-cycle start pulses when a defined code is written; any other
    // code is held for read-back but starts nothing.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_store_start  <= 1'b0;
            nv_recall_start <= 1'b0;
            nv_erase_start  <= 1'b0;
        end else if (clk_en) begin
            nv_store_start  <= 1'b0;
            nv_recall_start <= 1'b0;
            nv_erase_start  <= 1'b0;
            if (wr_hit(wr_q, reg_addr, `CTN_ADDR_NVRAM_CMD)) begin
                if (reg_wdata == `CTN_CODE_STORE) begin
                    nv_store_start <= 1'b1;
                end else if (reg_wdata == `CTN_CODE_RECALL) begin
                    nv_recall_start <= 1'b1;
                end else if (reg_wdata == `CTN_CODE_ERASE) begin
                    nv_erase_start <= 1'b1;
                end else begin
                    nv_store_start <= 1'b0;
                end
            end
        end
    end

    // NVRAM access check, answered combinationally so the serial decoder
    // can drop a locked access in the same cycle it asks.
    // No request, no permission.
    assign nv_access_allow = nv_access_req
        && !region_locked(nv_access_addr, nvram_region_guard[3:0]);

    // Frozen cycles hold every flag.
    // Unread tracking per result register.  A result refreshed in the
    // same cycle the host reads the old one stays marked unread, so the
    // new value is never skipped.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_unread <= '0;
        end else if (clk_en) begin
            result_unread <= (result_unread & ~result_read)
                           | (result_update & result_update_allow);
        end
    end

    // Refresh allowed when gating is off, or the held value was read.
    // Combinational, to grant in the read cycle.
    assign result_update_allow =
        alarm_and_filter_control[`CTN_BIT_GATED_UPDATE]
        ? (~result_unread | result_read)
        : '1;

    // Front end control follows the run switch directly.
    // Protection lifts after the write lands.
    assign frontend_run     = run_switch[0];
    assign frontend_protect = ~run_switch[0];

    // Configuration fields handed to the firmware.
    // No further decoding here.
    assign c_median_enable      = alarm_and_filter_control[`CTN_BIT_C_MEDIAN];
    assign r_median_enable      = alarm_and_filter_control[`CTN_BIT_R_MEDIAN];
    assign resistance_ratio_sel = resistance_ratio_select;
    assign pump_trim            = {nvram_pump_trim_high, nvram_pump_trim_low};

    // One cycle of latency buys clean ports.
    // Alarm outputs, registered to keep the ports glitch free.  Select 0
    // takes the Z source, select 1 the Theta source; both active high.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            general_port_zero <= 1'b0;
            general_port_one  <= 1'b0;
        end else if (clk_en) begin
            general_port_zero <= alarm_and_filter_control[`CTN_BIT_ALARM_LOW]
                                 ? alarm_theta[0] : alarm_z[0];
            general_port_one  <= alarm_and_filter_control[`CTN_BIT_ALARM_HIGH]
                                 ? alarm_theta[1] : alarm_z[1];
        end
    end

    // A frozen read is ignored.
    // Read data, registered one cycle after the read strobe.  Addresses
    // outside this bank return zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `CTN_RST_BYTE;
        end else if (rd_q) begin
            if (reg_addr == `CTN_ADDR_RATIO_SEL) begin
                reg_rdata <= resistance_ratio_select;
            end else if (reg_addr == `CTN_ADDR_ALARM_FILT) begin
                reg_rdata <= alarm_and_filter_control;
            end else if (reg_addr == `CTN_ADDR_RUN_SWITCH) begin
                reg_rdata <= run_switch;
            end else if (reg_addr == `CTN_ADDR_REGION_GUARD) begin
                reg_rdata <= nvram_region_guard;
            end else if (reg_addr == `CTN_ADDR_CUST_ID_LOW) begin
                reg_rdata <= customer_id_low;
            end else if (reg_addr == `CTN_ADDR_CUST_ID_HIGH) begin
                reg_rdata <= customer_id_high;
            end else if (reg_addr == `CTN_ADDR_NVRAM_CMD) begin
                reg_rdata <= nvram_command;
            end else if (reg_addr == `CTN_ADDR_TRIM_LOW) begin
                reg_rdata <= nvram_pump_trim_low;
            end else if (reg_addr == `CTN_ADDR_TRIM_HIGH) begin
                reg_rdata <= nvram_pump_trim_high;
            end else begin
                reg_rdata <= `CTN_RST_BYTE;
            end
        end
    end

endmodule

// >>> tb/ctn_config_tail_asserts.sv
`timescale 1ns/1ns

// Port checks; shadow registers follow the write strobes.
module ctn_config_tail_asserts #(
    parameter int NUM_RESULTS = 8
) (
    // Clock and reset.
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    // Register writes.
    input wire logic                   clk_en,
    input wire logic                   reg_wr,
    input wire ctn_pkg::ctn_addr_t     reg_addr,
    input wire ctn_pkg::ctn_byte_t     reg_wdata,
    // NVRAM guard, commands and result gating.
    input wire logic                   nv_access_req,
    input wire ctn_pkg::ctn_nv_addr_t  nv_access_addr,
    input wire logic                   nv_access_allow,
    input wire logic                   nv_erase_start,
    input wire logic [NUM_RESULTS-1:0] result_update,
    input wire logic [NUM_RESULTS-1:0] result_read,
    input wire logic [NUM_RESULTS-1:0] result_update_allow,
    // Run control, firmware byte and alarm port.
    input wire logic                   frontend_run,
    input wire logic                   frontend_protect,
    input wire ctn_pkg::ctn_byte_t     resistance_ratio_sel,
    input wire logic [1:0]             alarm_z,
    input wire logic [1:0]             alarm_theta,
    input wire logic                   general_port_zero
);
    import ctn_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ctn_byte_t  af;      // Shadow of the alarm and filter byte.
    logic [3:0] lk;      // Shadow of the lock nibble.
    logic       taken;   // A register write lands on this edge.
    logic       locked;  // The asked address sits in a locked region.

    assign taken  = reg_wr && clk_en;
    // Own range table, kept apart from the design's chain.
    assign locked = (nv_access_addr <= 10'h2bf) ? lk[0] :
                    (nv_access_addr <= 10'h33f) ? lk[1] :
                    (nv_access_addr <= 10'h3bf) ? lk[2] :
                    (nv_access_addr <= 10'h3ef || nv_access_addr >= 10'h3fe) && lk[3];

    // Shadows; unused bits are dropped.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            af <= 8'h00;
            lk <= 4'h0;
        end else if (taken && reg_addr == 6'h2a) begin
            af <= reg_wdata & 8'h5f;
        end else if (taken && reg_addr == 6'h30) begin
            lk <= reg_wdata[3:0];
        end
    end

    a_protect_inverse: assert property (frontend_protect != frontend_run)
        else $error("protect output is not the inverse of run");
    a_run_follows: assert property (
        taken && reg_addr == 6'h2f |=> frontend_run == $past(reg_wdata[0]))
        else $error("run output does not follow the written bit");
    a_lock_decode: assert property (
        nv_access_allow == (nv_access_req && !locked))
        else $error("NVRAM permission disagrees with the lock nibble");
    a_erase_code: assert property (
        taken && reg_addr == 6'h36 |=> nv_erase_start == ($past(reg_wdata) == 8'hb8))
        else $error("erase start does not match the written code");
    a_gate_open: assert property (
        !af[3] |-> result_update_allow == {NUM_RESULTS{1'b1}})
        else $error("update blocked while gating is off");
    a_gate_hold: assert property (
        af[3] && result_update[0] && result_update_allow[0]
        |=> !af[3] || result_read[0] || !result_update_allow[0])
        else $error("unread result was allowed a second update");
    a_alarm_route: assert property (
        clk_en |=> general_port_zero ==
        ($past(af[4]) ? $past(alarm_theta[0]) : $past(alarm_z[0])))
        else $error("port zero does not carry the selected alarm");
    a_ratio_store: assert property (
        taken && reg_addr == 6'h29 |=> resistance_ratio_sel == $past(reg_wdata))
        else $error("ratio select output does not hold the written byte");

    c_erase: cover property (nv_erase_start);
    c_locked: cover property (nv_access_req && !nv_access_allow);
    c_held: cover property (af[3] && !result_update_allow[0]);
endmodule

bind ctn_config_tail ctn_config_tail_asserts #(.NUM_RESULTS(NUM_RESULTS))
    u_ctn_config_tail_asserts (.ref_clk, .rst_n, .clk_en, .reg_wr, .reg_addr, .reg_wdata,
    .nv_access_req, .nv_access_addr, .nv_access_allow, .nv_erase_start, .result_update,
    .result_read, .result_update_allow, .frontend_run, .frontend_protect,
    .resistance_ratio_sel, .alarm_z, .alarm_theta, .general_port_zero);

// >>> tb/ctn_host_model.sv
`timescale 1ns/1ns

// Host on the serial port; strobes last one cycle.
module ctn_host_model (
    // Clock.
    input  wire logic               ref_clk,
    // Register strobes, address, data and activity.
    output logic                    reg_wr          = 1'b0,
    output logic                    reg_rd          = 1'b0,
    output ctn_pkg::ctn_addr_t      reg_addr        = 6'h00,
    output ctn_pkg::ctn_byte_t      reg_wdata       = 8'h00,
    output logic                    serial_activity = 1'b0,
    input  wire ctn_pkg::ctn_byte_t reg_rdata
);
    import ctn_pkg::*;
    // One write; trim is left alone, vendor bytes get zero.
    task automatic wr(input ctn_addr_t a, input ctn_byte_t d);
        if (a inside {6'h3e, 6'h3f}) begin
            return;
        end
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= (a inside {[6'h33:6'h35], [6'h37:6'h3d]}) ? 8'h00 : d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;   // Released data shows no stale byte.
    endtask
    // Configure with the run switch off.
    task automatic cfg(input ctn_addr_t a, input ctn_byte_t d);
        wr(6'h2f, 8'h00);
        wr(a, d);
    endtask
    // One read; data taken at the next falling edge.
    task automatic rd(input ctn_addr_t a, output ctn_byte_t d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    // One pulse of serial activity.
    task automatic act();
        @(posedge ref_clk);
        serial_activity <= 1'b1;
        @(posedge ref_clk);
        serial_activity <= 1'b0;
    endtask
endmodule

// >>> tb/ctn_config_tail_test.sv
`timescale 1ns/1ns

// Bench for the tail bank; each task runs one scenario and judges it.
module ctn_config_tail_test;
    import ctn_pkg::*;
    logic         ref_clk        = 1'b0;    // 10 MHz system clock.
    logic         rst_n          = 1'b0;    // Held low at start.
    logic         nv_access_req  = 1'b0;    // NVRAM permission request.
    logic         nv_erase_done  = 1'b0;    // Full erase finished.
    ctn_nv_addr_t nv_access_addr = 10'h000; // NVRAM word asked for.
    logic [7:0]   result_update  = 8'h00;   // New result wants in.
    logic [7:0]   result_read    = 8'h00;   // Host read a result.
    logic [1:0]   alarm_z        = 2'b00;   // First alarm source.
    logic [1:0]   alarm_theta    = 2'b00;   // Second alarm source.
    logic         reg_wr, reg_rd, serial_activity, nv_access_allow, frontend_run;
    logic         frontend_protect, c_median_enable, r_median_enable, nv_store_start;
    logic         nv_recall_start, nv_erase_start, general_port_zero, general_port_one;
    logic [7:0]   result_update_allow;
    logic [15:0]  pump_trim;
    ctn_addr_t    reg_addr;
    ctn_byte_t    reg_wdata, reg_rdata, resistance_ratio_sel, rd_val;
    int           err_count      = 0;
    int           checks_done    = 0;

    ctn_config_tail #(.NUM_RESULTS(8)) u_ctn_config_tail (.ref_clk, .rst_n, .clk_en(1'b1),
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .serial_activity,
        .nv_access_req, .nv_access_addr, .nv_access_allow, .nv_store_start,
        .nv_recall_start, .nv_erase_start, .nv_erase_done, .result_update, .result_read,
        .result_update_allow, .frontend_run, .frontend_protect, .c_median_enable,
        .r_median_enable, .resistance_ratio_sel, .pump_trim, .alarm_z, .alarm_theta,
        .general_port_zero, .general_port_one);
    ctn_host_model u_ctn_host_model (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .serial_activity, .reg_rdata);

    always #50 ref_clk = ~ref_clk;

    // Compares; a flag is widened so unknowns mismatch.
    task automatic chk_byte(input ctn_byte_t got, input ctn_byte_t exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic rd_is(input ctn_addr_t a, input ctn_byte_t e);
        u_ctn_host_model.rd(a, rd_val);
        chk_byte(rd_val, e);
    endtask
    // Verdict and end of run, shared with the watchdog.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset values, run switch, ratio byte and an unmapped read.
    task automatic t_run();
        chk_bit(frontend_protect, 1'b1);
        rd_is(6'h20, 8'h00);
        u_ctn_host_model.wr(6'h2f, 8'hff);
        rd_is(6'h2f, 8'h01);
        chk_bit(frontend_run, 1'b1);
        u_ctn_host_model.cfg(6'h29, 8'hc3);
        chk_bit(frontend_protect, 1'b1);
        rd_is(6'h29, 8'hc3);
        chk_byte(resistance_ratio_sel, 8'hc3);
        chk_byte(pump_trim[15:8] | pump_trim[7:0], 8'h00);
        $display("run test done");
    endtask
    // Every lock bit against every region boundary.
    task automatic t_lock();
        int pa[12] = '{0, 703, 704, 831, 832, 959, 960, 1007, 1008, 1021, 1022, 1023};
        int rg[12] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 3, 3};
        u_ctn_host_model.cfg(6'h30, 8'hff);
        rd_is(6'h30, 8'h0f);
        for (int i = 0; i < 5; i++) begin
            u_ctn_host_model.cfg(6'h30, (i < 4) ? 8'(1 << i) : 8'h0f);
            for (int j = 0; j < 12; j++) begin
                @(posedge ref_clk);
                nv_access_req  <= 1'b1;
                nv_access_addr <= 10'(pa[j]);
                @(negedge ref_clk);
                chk_bit(nv_access_allow, (i < 4) ? rg[j] != i : rg[j] == 4);
            end
        end
        $display("lock test done");
    endtask
    // Each command code, an undefined one, and clearing on later activity.
    task automatic t_cmd();
        ctn_byte_t code[4] = '{8'h2d, 8'h59, 8'hb8, 8'h5a};
        for (int k = 0; k < 4; k++) begin
            u_ctn_host_model.wr(6'h36, code[k]);
            #1;
            chk_bit(nv_store_start, k == 0);
            chk_bit(nv_recall_start, k == 1);
            chk_bit(nv_erase_start, k == 2);
            rd_is(6'h36, code[k]);
            u_ctn_host_model.act();
            rd_is(6'h36, 8'h00);
        end
        $display("command test done");
    endtask
    // Write-once serial bytes; the erase command alone clears nothing.
    task automatic t_serial();
        for (int a = 0; a < 2; a++) begin
            u_ctn_host_model.wr(6'h31 + 6'(a), 8'ha5);
            u_ctn_host_model.wr(6'h31 + 6'(a), 8'h3c);
            rd_is(6'h31 + 6'(a), 8'ha5);
        end
        u_ctn_host_model.wr(6'h36, 8'hb8);
        rd_is(6'h32, 8'ha5);
        @(posedge ref_clk);
        nv_erase_done <= 1'b1;
        @(posedge ref_clk);
        nv_erase_done <= 1'b0;
        rd_is(6'h31, 8'h00);
        u_ctn_host_model.wr(6'h31, 8'h5a);
        rd_is(6'h31, 8'h5a);
        $display("serial number test done");
    endtask
    // Gated updates, then filters and alarm routing.
    task automatic t_gate_alarm();
        u_ctn_host_model.cfg(6'h2a, 8'h08);
        @(posedge ref_clk);
        result_update <= 8'h01;
        @(posedge ref_clk);
        result_update <= 8'h00;
        result_read   <= 8'h02;
        @(negedge ref_clk);
        chk_byte(result_update_allow, 8'hfe);
        @(posedge ref_clk);
        result_read   <= 8'h01;
        alarm_theta   <= 2'b11;
        @(negedge ref_clk);
        chk_byte(result_update_allow, 8'hff);
        u_ctn_host_model.cfg(6'h2a, 8'hff);
        rd_is(6'h2a, 8'h5f);
        chk_bit(c_median_enable, 1'b1);
        chk_bit(general_port_zero, 1'b1);
        u_ctn_host_model.cfg(6'h2a, 8'h42);
        rd_is(6'h2a, 8'h42);
        chk_bit(r_median_enable, 1'b1);
        chk_bit(c_median_enable, 1'b0);
        chk_bit(general_port_zero, 1'b0);
        chk_bit(general_port_one, 1'b1);
        $display("gate and alarm test done");
    endtask

    // Twelve cycles of reset, then the scenarios.
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_run();
        t_lock();
        t_cmd();
        t_serial();
        t_gate_alarm();
        wrap_up();
    end
    // Watchdog: the scenarios need well under a thousand cycles.
    initial begin
        #(100 * 5000);
        err_count++;
        wrap_up();
    end
endmodule
